// file: rtl/charge_timer_ctrl.sv
// control logic: low-battery burst, power-on reset sync, debounce, scan readout
`timescale 1ns/1ps
`include "charge_timer_defines.svh"

// Behaviour
// - battery-low due gives exactly four square periods at 50% duty
// - each period lasts sixteen self-discharge ticks from the divider
// - rising supply sets reset; it reaches logic only after clock synchronisation
// - after all flops clear, an acknowledge clears the reset latch
// - discharge switch is debounced, ignoring bounce up to 10 ms
// - scan select high means scan mode; low or open means normal
// - scan mode shifts counter bits out on the shared output pin
// - counter MSB shows after last shift, LSB after penultimate, higher earlier
module charge_timer_ctrl #(
  parameter int unsigned DEBOUNCE_CYCLES = `CT_DEBOUNCE_CYC
) (
  input  wire logic                     sys_clk_i,              // 25 MHz on-chip clock
  input  wire logic                     arst_n_i,               // async reset, active low
  input  wire logic                     supply_up_i,            // supply sense, high when up
  input  wire logic                     discharge_request_n_i,  // switch, low when pressed
  input  wire logic                     scan_select_i,          // high selects scan mode
  input  wire logic                     scan_clk_i,             // shift clock on osc pin
  input  wire logic                     scan_serial_in_i,       // serial data into chain
  input  wire logic                     battery_low_due_i,      // pulse: start low burst
  input  wire logic                     self_tick_i,            // pulse: one f_S cycle
  input  wire logic                     count_up_i,             // pulse: counter up
  input  wire logic                     count_down_i,           // pulse: counter down
  output logic                          indicator_scan_o,       // shared low/scan pin
  output logic                          reset_ack_o,            // acknowledge pulse
  output logic                          discharge_start_o,      // debounced start pulse
  output logic                          logic_reset_o,          // synchronised reset level
  output logic [`CT_COUNTER_W-1:0]      counter_o               // counter value
);

  // the debounce counter is CT_DEB_W bits wide, so the window must fit in it;
  // a window of zero cycles would let every bounce edge through as a press
  if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES >= (1 << `CT_DEB_W)) begin : g_bad_debounce
    $error("DEBOUNCE_CYCLES out of range");
  end

  // last count of the debounce window
  localparam logic [`CT_DEB_W-1:0] DEB_LAST = `CT_DEB_W'(DEBOUNCE_CYCLES - 1);

  // whole state of the block in one struct, registered once
  charge_timer_pkg::state_s st;
  charge_timer_pkg::state_s next_st;

  // chain order: stage 0 is fed from scan input, stage 48 leaves first
  // stage 0 holds the counter msb and stages 1..9 hold bits 0..8, so the msb
  // is the last bit to leave and the lsb the one before it; the 39 stages
  // above the counter stand in for the divider and control flops of the
  // scan line, which this block keeps only as shift storage
  function automatic logic [`CT_SCAN_LEN-1:0] pack_chain(
    input logic [`CT_COUNTER_W-1:0] cnt,
    input logic [`CT_AUX_W-1:0]     aux
  );
    return {aux, cnt[8:0], cnt[9]};
  endfunction : pack_chain

  // next-state logic for every part of the block
  // priority: the synchronised reset wins over scan, and scan freezes the
  // counter, the debounce and the burst so that a readout never changes
  // what it reads; the power-on latch set is applied last so that a supply
  // rise that meets the acknowledge is never lost
  always_comb begin
    logic [`CT_SCAN_LEN-1:0] chain;
    logic                    sclk_rise;
    logic                    scan_mode;
    chain     = pack_chain(st.counter, st.aux);
    next_st   = st;
    sclk_rise = st.sclk_sync[1] & ~st.sclk_prev;
    scan_mode = st.sel_sync[1];

    // two-flop synchronisers on every pin input
    // only the second flop of each pair is read below; the first may still
    // be settling from a metastable capture
    next_st.por_sync  = {st.por_sync[0], supply_up_i};
    next_st.sel_sync  = {st.sel_sync[0], scan_select_i};
    next_st.sclk_sync = {st.sclk_sync[0], scan_clk_i};
    next_st.sin_sync  = {st.sin_sync[0], scan_serial_in_i};
    next_st.dis_sync  = {st.dis_sync[0], ~discharge_request_n_i};
    next_st.por_prev  = st.por_sync[1];
    next_st.sclk_prev = st.sclk_sync[1];
    next_st.reset_ack = 1'b0;
    next_st.dis_start = 1'b0;

    if (st.por_latch) begin
      // clear all working state while the synchronised reset holds
      // the acknowledge follows once every flop has taken its clear value
      next_st.deb_cnt    = '0;
      next_st.dis_stable = 1'b0;
      next_st.burst      = charge_timer_pkg::BURST_IDLE;
      next_st.tick_cnt   = '0;
      next_st.period_cnt = '0;
      next_st.counter    = `CT_COUNTER_RST;
      next_st.aux        = `CT_AUX_RST;
      next_st.pin_out    = 1'b0;
      // one cycle of clearing done, so acknowledge and drop the latch
      next_st.reset_ack  = 1'b1;
      next_st.por_latch  = 1'b0;
    end else if (scan_mode) begin
      // normal operation frozen; only shifting moves state
      // scan clock edges are found on the synchronised level, so the host
      // must hold each level for at least one system clock or a shift is missed
      if (sclk_rise) begin
        next_st.pin_out = chain[`CT_SCAN_LEN-1];
        chain           = {chain[`CT_SCAN_LEN-2:0], st.sin_sync[1]};
        next_st.counter = {chain[0], chain[9:1]};
        next_st.aux     = chain[`CT_SCAN_LEN-1:`CT_COUNTER_W];
      end
    end else begin
      // counter follows the timing control pulses
      // up and down together cancel, which keeps the count exact
      if (count_up_i && !count_down_i)
        next_st.counter = st.counter + `CT_COUNTER_W'(1);
      else if (count_down_i && !count_up_i)
        next_st.counter = st.counter - `CT_COUNTER_W'(1);

      // switch must stay at one level for the full window to count
      // a bounce back to the old level clears the count, so only a level
      // that stands for the whole window starts a discharge
      if (st.dis_sync[1] == st.dis_stable) begin
        next_st.deb_cnt = '0;
      end else if (st.deb_cnt == DEB_LAST) begin
        next_st.deb_cnt    = '0;
        next_st.dis_stable = st.dis_sync[1];
        next_st.dis_start  = st.dis_sync[1];
      end else begin
        next_st.deb_cnt = st.deb_cnt + `CT_DEB_W'(1);
      end

      // low-battery burst: high half then low half, counted in f_S ticks
      // the burst ignores a new request while it runs; the divider tick
      // paces both halves, so the duty cycle is exact whatever the tick rate
      case (st.burst)
        charge_timer_pkg::BURST_IDLE: begin
          // pin rises one cycle after the request
          next_st.pin_out = 1'b0;
          if (battery_low_due_i) begin
            next_st.burst      = charge_timer_pkg::BURST_HIGH;
            next_st.tick_cnt   = '0;
            next_st.period_cnt = '0;
            next_st.pin_out    = 1'b1;
          end
        end
        charge_timer_pkg::BURST_HIGH: begin
          next_st.pin_out = 1'b1;
          if (self_tick_i) begin
            next_st.tick_cnt = st.tick_cnt + 5'h01;
            if (st.tick_cnt + 5'h01 == `CT_TICKS_HALF) begin
              next_st.burst   = charge_timer_pkg::BURST_LOW;
              next_st.pin_out = 1'b0;
            end
          end
        end
        charge_timer_pkg::BURST_LOW: begin
          next_st.pin_out = 1'b0;
          if (self_tick_i) begin
            next_st.tick_cnt = st.tick_cnt + 5'h01;
            if (st.tick_cnt + 5'h01 == `CT_TICKS_PER_PER) begin
              next_st.tick_cnt   = '0;
              next_st.period_cnt = st.period_cnt + 3'h1;
              if (st.period_cnt + 3'h1 == `CT_BURST_PERIODS) begin
                next_st.burst = charge_timer_pkg::BURST_IDLE;
              end else begin
                next_st.burst   = charge_timer_pkg::BURST_HIGH;
                next_st.pin_out = 1'b1;
              end
            end
          end
        end
        default: begin
          // an illegal state returns to idle with the pin low
          next_st.burst   = charge_timer_pkg::BURST_IDLE;
          next_st.pin_out = 1'b0;
        end
      endcase
    end

    // a rising supply sets the latch; set wins over the acknowledge
    // the edge is taken on the synchronised level, one cycle after it settles
    if (st.por_sync[1] && !st.por_prev)
      next_st.por_latch = 1'b1;

    // leaving scan mode needs no extra step: the burst case drives the pin
    // on every normal cycle, so the last shifted bit is dropped at once
  end

  // single state register; reset value puts the latch up so logic starts clean
  // the supply sync flops start high so that the release of the async reset
  // is not seen as a second supply rise and acknowledged twice
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st            <= '0;
      st.por_latch  <= 1'b1;
      st.burst      <= charge_timer_pkg::BURST_IDLE;
      st.dis_stable <= 1'b0;
      st.por_sync   <= 2'h3;
      st.por_prev   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // all outputs straight from state flops
  // the shared pin shows the burst in normal mode and the chain in scan mode
  assign indicator_scan_o  = st.pin_out;
  assign reset_ack_o       = st.reset_ack;
  assign discharge_start_o = st.dis_start;
  assign logic_reset_o     = st.por_latch;
  assign counter_o         = st.counter;

endmodule : charge_timer_ctrl

// file: rtl/charge_timer_defines.svh
// constants for the charge timer control and scan readout block
`ifndef CHARGE_TIMER_DEFINES_SVH
`define CHARGE_TIMER_DEFINES_SVH

`define CT_CLK_HZ          25000000
`define CT_COUNTER_W       10
`define CT_SCAN_LEN        49
`define CT_AUX_W           39
`define CT_BURST_PERIODS   3'h4
`define CT_TICKS_PER_PER   5'h10
`define CT_TICKS_HALF      5'h08
`define CT_DEBOUNCE_MS     10
`define CT_DEBOUNCE_CYC    ((`CT_DEBOUNCE_MS * `CT_CLK_HZ + 999) / 1000)
`define CT_DEB_W           20
`define CT_COUNTER_RST     10'h000
`define CT_AUX_RST         39'h00_0000_0000

`endif

// file: rtl/charge_timer_pkg.sv
// types for the charge timer control and scan readout block
`include "charge_timer_defines.svh"

package charge_timer_pkg;

  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_HIGH,
    BURST_LOW
  } burst_e;

  typedef struct packed {
    logic [1:0]               por_sync;
    logic                     por_prev;
    logic                     por_latch;
    logic                     reset_ack;
    logic [1:0]               sel_sync;
    logic [1:0]               sclk_sync;
    logic                     sclk_prev;
    logic [1:0]               sin_sync;
    logic [1:0]               dis_sync;
    logic [`CT_DEB_W-1:0]     deb_cnt;
    logic                     dis_stable;
    logic                     dis_start;
    burst_e                   burst;
    logic [4:0]               tick_cnt;
    logic [2:0]               period_cnt;
    logic [`CT_COUNTER_W-1:0] counter;
    logic [`CT_AUX_W-1:0]     aux;
    logic                     pin_out;
  } state_s;

endpackage : charge_timer_pkg

// file: verification/charge_timer_ctrl_sva.sv
// port checker for the charge timer control block
`timescale 1ns/1ps
`include "charge_timer_defines.svh"
module charge_timer_ctrl_sva (
  input wire logic sys_clk_i, arst_n_i, supply_up_i, discharge_request_n_i, scan_select_i,
  input wire logic scan_clk_i, scan_serial_in_i, battery_low_due_i, self_tick_i, count_up_i,
  input wire logic count_down_i, indicator_scan_o, reset_ack_o, discharge_start_o,
  input wire logic logic_reset_o,
  input wire logic [`CT_COUNTER_W-1:0] counter_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [3:0] sel_hist;
  // select history spans the sync delay, so burst checks skip scan entry and exit
  always_ff @(posedge sys_clk_i) sel_hist <= {sel_hist[2:0], scan_select_i};
  wire quiet = !scan_select_i && sel_hist == 4'h0;
  a_ack_after_por: assert property ($rose(logic_reset_o) |=> reset_ack_o)
    else $error("no acknowledge");
  a_ack_pulse: assert property (reset_ack_o |=> !reset_ack_o)
    else $error("acknowledge held");
  a_por_clears: assert property (logic_reset_o |=> counter_o == 10'h000)
    else $error("counter kept");
  a_start_pulse: assert property (discharge_start_o |=> !discharge_start_o)
    else $error("start held");
  a_rise_cause: assert property ($rose(indicator_scan_o) && quiet |->
    $past(battery_low_due_i) || $past(self_tick_i)) else $error("rise without cause");
  a_fall_on_tick: assert property ($fell(indicator_scan_o) && quiet |->
    $past(self_tick_i)) else $error("fall without tick");
  a_high_eight: assert property ($rose(indicator_scan_o) && quiet |=>
    indicator_scan_o [*7]) else $error("high phase short");
  a_shift_clock: assert property ($changed(indicator_scan_o) && sel_hist == 4'hF |->
    $past(scan_clk_i, 2)) else $error("shift without clock");
endmodule : charge_timer_ctrl_sva

bind charge_timer_ctrl charge_timer_ctrl_sva i_sva (.*);

// file: verification/scan_host.sv
// scan reader model: selects scan mode, clocks the chain, loops the pin back
`timescale 1ns/1ps
module scan_host (
  input  wire logic sys_clk_i,  // pacing clock
  input  wire logic pin_i,      // shared indicator/scan pin
  output logic      select_o,   // scan select
  output logic      sclk_o,     // shift clock
  output logic      sin_o       // chain input
);
  initial {select_o, sclk_o, sin_o} = 3'h0;
  // one shift: data and clock rise together, each level held four clocks
  // so it outlasts the design's two sync flops and edge detector
  task automatic shift_one(input logic din, output logic dout);
    sin_o  <= din;
    sclk_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    dout = pin_i;
    sclk_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask : shift_one
  // read the chain, then shift the captured bits back in so nothing is lost
  task automatic unload(output logic [48:0] bits);
    logic dummy;
    @(posedge sys_clk_i) select_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    for (int i = 0; i < 49; i++) shift_one(1'b0, bits[i]);
    for (int i = 0; i < 49; i++) shift_one(bits[i], dummy);
    select_o <= 1'b0;
    sin_o    <= 1'b0;
  endtask : unload
endmodule : scan_host

// file: verification/test_charge_timer_scan_readout.sv
// self-checking bench for the charge timer scan readout
`timescale 1ns/1ps
`include "charge_timer_defines.svh"
module test_charge_timer_scan_readout;
  logic sys_clk_i, arst_n_i, supply_up_i, discharge_request_n_i, scan_select_i, scan_clk_i;
  logic scan_serial_in_i, battery_low_due_i, self_tick_i, count_up_i, count_down_i, tick_en;
  logic indicator_scan_o, reset_ack_o, discharge_start_o, logic_reset_o;
  logic [`CT_COUNTER_W-1:0] counter_o;
  logic [48:0] bits;
  int n_fail, check_count, cyc, ups, hi;
  charge_timer_ctrl #(.DEBOUNCE_CYCLES(8)) i_dut (.*);
  scan_host i_host (.sys_clk_i, .pin_i(indicator_scan_o), .select_o(scan_select_i),
    .sclk_o(scan_clk_i), .sin_o(scan_serial_in_i));
  // clock, and a tick every other cycle while enabled
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) self_tick_i <= tick_en & !self_tick_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %0h not %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("%0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // the run needs about 2100 cycles, so 8000 means a hang
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // high cycles and rising edges of one output over n cycles
  task automatic watch(input int n, ref logic sig);
    logic prev;
    prev = 1'b0;
    hi = 0;
    ups = 0;
    repeat (n) begin
      @(negedge sys_clk_i);
      hi += sig;
      ups += sig & !prev;
      prev = sig;
    end
  endtask : watch
  task automatic test_burst;
    battery_low_due_i <= 1'b1;
    @(posedge sys_clk_i) battery_low_due_i <= 1'b0;
    tick_en <= 1'b1;
    watch(140, indicator_scan_o);
    check(ups, 4);
    check(hi, 64);
    tick_en <= 1'b0;
    $display("burst test done");
  endtask : test_burst
  task automatic test_scan;
    repeat ('h205) begin
      @(posedge sys_clk_i) count_up_i <= 1'b1;
      @(posedge sys_clk_i) count_up_i <= 1'b0;
    end
    @(posedge sys_clk_i) {count_up_i, count_down_i} <= 2'h3;
    @(posedge sys_clk_i) {count_up_i, count_down_i} <= 2'h0;
    i_host.unload(bits);
    check(bits[48:39], 10'h340);
    check(bits[48:45], 4'hD);
    repeat (8) @(posedge sys_clk_i);
    check(counter_o, 10'h205);
    $display("scan test done");
  endtask : test_scan
  task automatic test_debounce;
    discharge_request_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    discharge_request_n_i <= 1'b1;
    watch(14, discharge_start_o);
    check(ups, 0);
    @(posedge sys_clk_i) discharge_request_n_i <= 1'b0;
    watch(30, discharge_start_o);
    check(ups, 1);
    $display("debounce test done");
  endtask : test_debounce
  task automatic test_por;
    @(posedge sys_clk_i) supply_up_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    supply_up_i <= 1'b1;
    watch(12, reset_ack_o);
    check(ups, 1);
    check(counter_o, 10'h000);
    $display("power-on reset test done");
  endtask : test_por
  // reset, then the scenarios in turn
  initial begin
    {arst_n_i, battery_low_due_i, count_up_i, count_down_i, tick_en, self_tick_i} = '0;
    {supply_up_i, discharge_request_n_i} = 2'h3;
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    check(logic_reset_o, 1'b0);
    test_burst();
    test_scan();
    test_debounce();
    test_por();
    tally_and_finish();
  end
endmodule : test_charge_timer_scan_readout
